/* File: hsi_pkg.sv */
// ==========================================================
// host serial interface constants
package hsi_pkg;
   // ==========================================================
   // clock and line rates
   localparam int unsigned CLK_HZ      = 100_000_000;
   localparam int unsigned BAUD_115200 = 115_200;
   localparam int unsigned BAUD_9600   = 9_600;
   localparam int unsigned BAUD_19200  = 19_200;
   localparam int unsigned BAUD_38400  = 38_400;
   localparam int unsigned DIV_W       = 14;
   localparam logic [13:0] DIV_115200  = 14'(CLK_HZ / BAUD_115200);
   localparam logic [13:0] DIV_9600    = 14'(CLK_HZ / BAUD_9600);
   localparam logic [13:0] DIV_19200   = 14'(CLK_HZ / BAUD_19200);
   localparam logic [13:0] DIV_38400   = 14'(CLK_HZ / BAUD_38400);
   localparam logic [13:0] DIV_ONE     = 14'h0001;
   localparam logic [2:0]  LAST_BIT    = 3'h7;
   localparam logic [2:0]  FIRST_BIT   = 3'h0;
   localparam logic [2:0]  BIT_STEP    = 3'h1;

   // strap codes {rate_strap_high, rate_strap_low}
   localparam logic [1:0] RATE_115200 = 2'h0;
   localparam logic [1:0] RATE_9600   = 2'h1;
   localparam logic [1:0] RATE_19200  = 2'h2;
   localparam logic [1:0] RATE_38400  = 2'h3;

   // oscillator settle count, in oscillator pulses
   localparam int unsigned OSC_SETTLE_PULSES = 4096;
   localparam int unsigned OSC_W             = 13;

   // ==========================================================
   // register indices
   localparam logic [7:0] REG_CONFIG    = 8'h00;
   localparam logic [7:0] REG_STATUS    = 8'h01;
   localparam logic [7:0] REG_TX_DATA   = 8'h02;
   localparam logic [7:0] REG_RX_DATA   = 8'h03;
   localparam logic [7:0] REG_BOOT_CTRL = 8'h04;
   localparam logic [7:0] REG_GPIO_OUT  = 8'h05;
   localparam logic [7:0] REG_GPIO_OE   = 8'h06;
   localparam logic [7:0] REG_GPIO_IN   = 8'h07;
   localparam logic [3:0] MEM_PAGE      = 4'h1;
   localparam int unsigned MEM_DEPTH    = 16;

   // reset values and field positions
   localparam logic [7:0] CONFIG_RST    = 8'h00;
   localparam logic [2:0] BOOT_RST      = 3'h0;
   localparam logic [2:0] GPIO_RST      = 3'h0;
   localparam logic [7:0] ZERO_BYTE     = 8'h00;
   localparam int unsigned CFG_TIMING_BIT = 7;
   localparam int unsigned BOOT_DONE_BIT  = 0;
   localparam int unsigned BOOT_LED_BIT   = 1;
   localparam int unsigned BOOT_AUX_BIT   = 2;

   // ==========================================================
   // bit period in system clocks for a latched rate code
   function automatic logic [13:0] hsi_bit_cycles(input logic [1:0] sel);
      case (sel)
         RATE_9600:  hsi_bit_cycles = DIV_9600;
         RATE_19200: hsi_bit_cycles = DIV_19200;
         RATE_38400: hsi_bit_cycles = DIV_38400;
         default:    hsi_bit_cycles = DIV_115200;
      endcase
   endfunction

   // count loaded for a period of the given length, ending at zero
   function automatic logic [13:0] hsi_reload(input logic [13:0] cycles);
      hsi_reload = cycles - DIV_ONE;
   endfunction
endpackage

/* File: hsi_rx_if.sv */
`timescale 1ns/1ps
// ==========================================================
// receiver link between top and receive engine
interface hsi_rx_if;
   logic [13:0] bit_cycles;
   logic        line;
   logic [7:0]  data;
   logic        valid;
   logic        frame_err;

   modport engine (input bit_cycles, input line, output data, output valid, output frame_err);
   modport owner  (output bit_cycles, output line, input data, input valid, input frame_err);
endinterface

/* File: hsi_rx.sv */
`timescale 1ns/1ps
// ==========================================================
// receive engine: start edge, centre sampling, stop check
module hsi_rx (
   // clock and reset
   input wire logic  sys_clk,
   input wire logic  rst_n,
   // link to top
   hsi_rx_if.engine  rx
);
   import hsi_pkg::*;

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} hsi_rx_state_type;

   hsi_rx_state_type rx_state_q, rx_state_d;
   logic [13:0]      cnt_q, cnt_d;
   logic [2:0]       bit_q, bit_d;
   logic [7:0]       shift_q, shift_d;
   logic             prev_q, prev_d;
   logic [7:0]       data_q, data_d;
   logic             valid_q, valid_d;
   logic             ferr_q, ferr_d;

   // ==========================================================
   // next state
   always_comb begin
      rx_state_d = rx_state_q;
      cnt_d      = cnt_q;
      bit_d      = bit_q;
      shift_d    = shift_q;
      prev_d     = rx.line;
      data_d     = data_q;
      valid_d    = 1'b0;
      ferr_d     = 1'b0;
      if (cnt_q != 14'h0000) begin
         cnt_d = cnt_q - DIV_ONE;
      end
      case (rx_state_q)
         RX_IDLE: begin
            if (prev_q && !rx.line) begin
               rx_state_d = RX_START;
               cnt_d      = hsi_reload(rx.bit_cycles >> 1);
            end
         end
         RX_START: begin
            if (cnt_q == 14'h0000) begin
               // a glitch shorter than half a bit is dropped
               if (!rx.line) begin
                  rx_state_d = RX_DATA;
                  cnt_d      = hsi_reload(rx.bit_cycles);
                  bit_d      = FIRST_BIT;
               end else begin
                  rx_state_d = RX_IDLE;
               end
            end
         end
         RX_DATA: begin
            if (cnt_q == 14'h0000) begin
               shift_d = {rx.line, shift_q[7:1]};
               cnt_d   = hsi_reload(rx.bit_cycles);
               bit_d   = bit_q + BIT_STEP;
               if (bit_q == LAST_BIT) begin
                  rx_state_d = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            if (cnt_q == 14'h0000) begin
               data_d     = shift_q;
               valid_d    = rx.line;
               ferr_d     = !rx.line;
               rx_state_d = RX_IDLE;
            end
         end
         default: rx_state_d = RX_IDLE;
      endcase
   end

   // ==========================================================
   // registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rx_state_q <= RX_IDLE;
         cnt_q      <= 14'h0000;
         bit_q      <= FIRST_BIT;
         shift_q    <= ZERO_BYTE;
         prev_q     <= 1'b1;
         data_q     <= ZERO_BYTE;
         valid_q    <= 1'b0;
         ferr_q     <= 1'b0;
      end else begin
         rx_state_q <= rx_state_d;
         cnt_q      <= cnt_d;
         bit_q      <= bit_d;
         shift_q    <= shift_d;
         prev_q     <= prev_d;
         data_q     <= data_d;
         valid_q    <= valid_d;
         ferr_q     <= ferr_d;
      end
   end

   assign rx.data      = data_q;
   assign rx.valid     = valid_q;
   assign rx.frame_err = ferr_q;
endmodule

/* File: hsi_top.sv */
`timescale 1ns/1ps
//
// Function
// - each character is one start bit, eight data bits lsb first and one stop bit, both ways.
// - bit rates from 9600 to 115200 baud, chosen only by the rate straps.
// - characters leave on the serial output pin and arrive on the serial input pin.
// - the serial output only pulls low; an external pull-up makes the high level.
// - the straps are caught when reset ends and held until the next reset.
// - straps high,low 00 give 115200, 01 give 9600, 10 give 19200, 11 give 38400 baud.
// - config bit 7 clear puts the preslot sync signal on the timing pin.
// - config bit 7 set puts baseband data on the timing pin, high for space, low for mark.
// - the block stays in hard reset while the reset pin is low.
// - hard reset clears the core logic but not the oscillator gate, and leaves the data memory as it was.
// - after power-up the clock output stays gated until enough oscillator pulses are counted.
// - during boot the boot select pin is an input; held low it asks for serial upload.
// - during boot the led and aux pins are outputs showing the loader status.
// - once firmware is loaded the three boot pins become plain general purpose pins.
//
module hsi_top #(
   parameter int unsigned OSC_SETTLE = hsi_pkg::OSC_SETTLE_PULSES
) (
   // clock and power-on reset
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   // register port
   input  wire logic [7:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [7:0]               reg_rdata,
   // serial pins
   input  wire logic                serial_in_pin,
   input  wire logic                serial_out_pin_i,
   output logic                     serial_out_pin_o,
   output logic                     serial_out_pin_oe,
   // straps and hard reset pin
   input  wire logic                rate_strap_low,
   input  wire logic                rate_strap_high,
   input  wire logic                reset_in_n,
   // timing output
   input  wire logic                preslot_sync,
   input  wire logic                tx_space_symbol,
   output logic                     timing_out_pin,
   // oscillator gate
   output logic                     osc_clk_enable,
   // boot role pins
   input  wire logic                boot_led_status_i,
   output logic                     boot_led_status_o,
   output logic                     boot_led_status_oe,
   input  wire logic                boot_status_aux_i,
   output logic                     boot_status_aux_o,
   output logic                     boot_status_aux_oe,
   input  wire logic                boot_select_in_i,
   output logic                     boot_select_in_o,
   output logic                     boot_select_in_oe
);
   import hsi_pkg::*;

   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} hsi_tx_state_type;

   // ==========================================================
   // pin synchronisers
   logic [1:0] rst_pin_s;
   logic [1:0] strap_lo_s, strap_hi_s, rxd_s;
   logic [2:0] gpio_s1, gpio_s2;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rst_pin_s  <= 2'h0;
         strap_lo_s <= 2'h0;
         strap_hi_s <= 2'h0;
         rxd_s      <= 2'h3;
         gpio_s1    <= 3'h0;
         gpio_s2    <= 3'h0;
      end else begin
         rst_pin_s  <= {rst_pin_s[0], reset_in_n};
         strap_lo_s <= {strap_lo_s[0], rate_strap_low};
         strap_hi_s <= {strap_hi_s[0], rate_strap_high};
         rxd_s      <= {rxd_s[0], serial_in_pin};
         gpio_s1    <= {boot_select_in_i, boot_status_aux_i, boot_led_status_i};
         gpio_s2    <= gpio_s1;
      end
   end

   // ==========================================================
   // oscillator settle gate, cleared only at power-on
   logic [12:0] osc_cnt_q, osc_cnt_d;
   logic        osc_rdy_q, osc_rdy_d;

   always_comb begin
      osc_cnt_d = osc_cnt_q;
      osc_rdy_d = osc_rdy_q;
      if (!osc_rdy_q) begin
         osc_cnt_d = osc_cnt_q + 13'h0001;
         osc_rdy_d = (osc_cnt_q == 13'(OSC_SETTLE - 1));
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         osc_cnt_q <= 13'h0000;
         osc_rdy_q <= 1'b0;
      end else begin
         osc_cnt_q <= osc_cnt_d;
         osc_rdy_q <= osc_rdy_d;
      end
   end

   assign osc_clk_enable = osc_rdy_q;

   // ==========================================================
   // hard reset and strap latch
   logic       core_rst_n;
   logic       core_rst_n_q;
   logic [1:0] rate_sel_q, rate_sel_d;

   // logic also waits for the oscillator so straps are caught on a clean clock
   assign core_rst_n = rst_n && rst_pin_s[1] && osc_rdy_q;

   always_comb begin
      rate_sel_d = rate_sel_q;
      if (core_rst_n && !core_rst_n_q) begin
         rate_sel_d = {strap_hi_s[1], strap_lo_s[1]};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         core_rst_n_q <= 1'b0;
         rate_sel_q   <= RATE_115200;
      end else begin
         core_rst_n_q <= core_rst_n;
         rate_sel_q   <= rate_sel_d;
      end
   end

   logic [13:0] bit_cycles;
   assign bit_cycles = hsi_bit_cycles(rate_sel_q);

   // ==========================================================
   // receiver
   hsi_rx_if rx_link ();
   assign rx_link.bit_cycles = bit_cycles;
   assign rx_link.line       = rxd_s[1];

   hsi_rx u_rx (
      .sys_clk (sys_clk),
      .rst_n   (core_rst_n),
      .rx      (rx_link.engine)
   );

   // ==========================================================
   // transmitter
   hsi_tx_state_type tx_state_q, tx_state_d;
   logic [13:0]      tx_cnt_q, tx_cnt_d;
   logic [2:0]       tx_bit_q, tx_bit_d;
   logic [7:0]       tx_shift_q, tx_shift_d;
   logic             tx_line_q, tx_line_d;
   logic             tx_go;

   // a write while busy is dropped; software polls the busy flag
   assign tx_go = reg_wr && (reg_addr == REG_TX_DATA) && (tx_state_q == TX_IDLE);

   always_comb begin
      tx_state_d = tx_state_q;
      tx_cnt_d   = tx_cnt_q;
      tx_bit_d   = tx_bit_q;
      tx_shift_d = tx_shift_q;
      tx_line_d  = tx_line_q;
      if (tx_cnt_q != 14'h0000) begin
         tx_cnt_d = tx_cnt_q - DIV_ONE;
      end
      case (tx_state_q)
         TX_IDLE: begin
            tx_line_d = 1'b1;
            if (tx_go) begin
               tx_shift_d = reg_wdata;
               tx_line_d  = 1'b0;
               tx_cnt_d   = hsi_reload(bit_cycles);
               tx_state_d = TX_START;
            end
         end
         TX_START: begin
            if (tx_cnt_q == 14'h0000) begin
               tx_line_d  = tx_shift_q[0];
               tx_cnt_d   = hsi_reload(bit_cycles);
               tx_bit_d   = FIRST_BIT;
               tx_state_d = TX_DATA;
            end
         end
         TX_DATA: begin
            if (tx_cnt_q == 14'h0000) begin
               tx_cnt_d = hsi_reload(bit_cycles);
               if (tx_bit_q == LAST_BIT) begin
                  tx_line_d  = 1'b1;
                  tx_state_d = TX_STOP;
               end else begin
                  tx_shift_d = tx_shift_q >> 1;
                  tx_line_d  = tx_shift_q[1];
                  tx_bit_d   = tx_bit_q + BIT_STEP;
               end
            end
         end
         TX_STOP: begin
            if (tx_cnt_q == 14'h0000) begin
               tx_state_d = TX_IDLE;
            end
         end
         default: tx_state_d = TX_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!core_rst_n) begin
         tx_state_q <= TX_IDLE;
         tx_cnt_q   <= 14'h0000;
         tx_bit_q   <= FIRST_BIT;
         tx_shift_q <= ZERO_BYTE;
         tx_line_q  <= 1'b1;
      end else begin
         tx_state_q <= tx_state_d;
         tx_cnt_q   <= tx_cnt_d;
         tx_bit_q   <= tx_bit_d;
         tx_shift_q <= tx_shift_d;
         tx_line_q  <= tx_line_d;
      end
   end

   // open drain: never drive high, pull-up gives the one
   assign serial_out_pin_o  = 1'b0;
   assign serial_out_pin_oe = !tx_line_q;

   // ==========================================================
   // registers
   logic [7:0] cfg_q, cfg_d;
   logic [2:0] boot_q, boot_d;
   logic [2:0] gpo_q, gpo_d;
   logic [2:0] gpoe_q, gpoe_d;
   logic [7:0] rx_byte_q, rx_byte_d;
   logic       rx_full_q, rx_full_d;
   logic       rx_ovr_q, rx_ovr_d;
   logic       rx_ferr_q, rx_ferr_d;
   logic [7:0] rdata_q, rdata_d;
   logic       rx_take;
   logic       mem_hit;
   logic [7:0] status;

   assign rx_take = reg_rd && (reg_addr == REG_RX_DATA);
   assign mem_hit = (reg_addr[7:4] == MEM_PAGE);
   assign status  = {rx_full_q, rx_ferr_q, rx_ovr_q, (tx_state_q != TX_IDLE),
                     osc_rdy_q, !gpio_s2[2], rate_sel_q};

   always_comb begin
      cfg_d     = cfg_q;
      boot_d    = boot_q;
      gpo_d     = gpo_q;
      gpoe_d    = gpoe_q;
      rx_byte_d = rx_byte_q;
      // clear on read, a new event in the same cycle wins
      rx_full_d = rx_full_q && !rx_take;
      rx_ovr_d  = rx_ovr_q && !rx_take;
      rx_ferr_d = rx_ferr_q && !rx_take;
      if (rx_link.valid) begin
         rx_byte_d = rx_link.data;
         rx_full_d = 1'b1;
         rx_ovr_d  = rx_ovr_d || (rx_full_q && !rx_take);
      end
      if (rx_link.frame_err) begin
         rx_ferr_d = 1'b1;
      end
      if (reg_wr) begin
         case (reg_addr)
            REG_CONFIG:    cfg_d  = reg_wdata;
            REG_BOOT_CTRL: boot_d = reg_wdata[2:0];
            REG_GPIO_OUT:  gpo_d  = reg_wdata[2:0];
            REG_GPIO_OE:   gpoe_d = reg_wdata[2:0];
            default:       cfg_d  = cfg_q;
         endcase
      end
      rdata_d = ZERO_BYTE;
      if (reg_rd) begin
         case (reg_addr)
            REG_CONFIG:    rdata_d = cfg_q;
            REG_STATUS:    rdata_d = status;
            REG_RX_DATA:   rdata_d = rx_byte_q;
            REG_BOOT_CTRL: rdata_d = {5'h00, boot_q};
            REG_GPIO_OUT:  rdata_d = {5'h00, gpo_q};
            REG_GPIO_OE:   rdata_d = {5'h00, gpoe_q};
            REG_GPIO_IN:   rdata_d = {5'h00, gpio_s2};
            default:       rdata_d = ZERO_BYTE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!core_rst_n) begin
         cfg_q     <= CONFIG_RST;
         boot_q    <= BOOT_RST;
         gpo_q     <= GPIO_RST;
         gpoe_q    <= GPIO_RST;
         rx_byte_q <= ZERO_BYTE;
         rx_full_q <= 1'b0;
         rx_ovr_q  <= 1'b0;
         rx_ferr_q <= 1'b0;
      end else begin
         cfg_q     <= cfg_d;
         boot_q    <= boot_d;
         gpo_q     <= gpo_d;
         gpoe_q    <= gpoe_d;
         rx_byte_q <= rx_byte_d;
         rx_full_q <= rx_full_d;
         rx_ovr_q  <= rx_ovr_d;
         rx_ferr_q <= rx_ferr_d;
      end
   end

   // ==========================================================
   // data memory, no reset on purpose so it survives hard reset
   logic [7:0] data_mem [MEM_DEPTH];
   logic [7:0] mem_rd_q;

   always_ff @(posedge sys_clk) begin
      if (reg_wr && mem_hit) begin
         data_mem[reg_addr[3:0]] <= reg_wdata;
      end
      mem_rd_q <= data_mem[reg_addr[3:0]];
   end

   logic mem_rd_q2;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdata_q   <= ZERO_BYTE;
         mem_rd_q2 <= 1'b0;
      end else begin
         rdata_q   <= rdata_d;
         mem_rd_q2 <= reg_rd && mem_hit;
      end
   end

   assign reg_rdata = mem_rd_q2 ? mem_rd_q : rdata_q;

   // ==========================================================
   // timing pin and boot role pins
   logic timing_q, timing_d;
   logic boot_done;

   assign boot_done = boot_q[BOOT_DONE_BIT];

   always_comb begin
      timing_d = cfg_q[CFG_TIMING_BIT] ? tx_space_symbol
                                       : preslot_sync;
   end

   always_ff @(posedge sys_clk) begin
      if (!core_rst_n) begin
         timing_q <= 1'b0;
      end else begin
         timing_q <= timing_d;
      end
   end

   assign timing_out_pin = timing_q;

   // loader status while booting, software control once loaded
   assign boot_led_status_o  = boot_done ? gpo_q[0] : boot_q[BOOT_LED_BIT];
   assign boot_led_status_oe = boot_done ? gpoe_q[0] : 1'b1;
   assign boot_status_aux_o  = boot_done ? gpo_q[1] : boot_q[BOOT_AUX_BIT];
   assign boot_status_aux_oe = boot_done ? gpoe_q[1] : 1'b1;
   assign boot_select_in_o   = gpo_q[2];
   assign boot_select_in_oe  = boot_done && gpoe_q[2];
endmodule

/* File: hsi_host_model.sv */
`timescale 1ns/1ps
// ==========================================
// host controller uart: 8n1 at one fixed rate
module hsi_host_model #(
   parameter int BIT = 868
) (
   // clock
   input  wire logic sys_clk,
   // line from device (pulled up), line to device
   input  wire logic line_rx,
   output logic      line_tx
);
   logic [7:0] got_byte = 8'h00;
   int         got_cnt  = 0;
   initial line_tx = 1'b1;
   // start low, data lsb first, stop high unless a fault is asked
   task automatic send(input logic [7:0] b, input logic stop_bit);
      logic [9:0] f;
      f = {stop_bit, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_tx <= f[i];
         repeat (BIT) @(posedge sys_clk);
      end
      line_tx <= 1'b1;
   endtask
   // mid-bit sampling; counts a byte half way through its stop bit, without checking it
   always begin
      @(negedge line_rx);
      repeat (BIT / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge sys_clk);
         got_byte[i] = line_rx;
      end
      repeat (BIT) @(posedge sys_clk);
      got_cnt++;
   end
endmodule

/* File: hsi_top_asserts.sv */
`timescale 1ns/1ps
// ==========================================
// port checks for the host serial interface
module hsi_top_asserts #(
   parameter int unsigned OSC_SETTLE = 16
) (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       rst_n,
   // register writes
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   // pins
   input wire logic       serial_out_pin_o,
   input wire logic       serial_out_pin_oe,
   input wire logic       reset_in_n,
   input wire logic       preslot_sync,
   input wire logic       tx_space_symbol,
   input wire logic       timing_out_pin,
   input wire logic       osc_clk_enable,
   input wire logic       boot_led_status_oe,
   input wire logic       boot_status_aux_oe,
   input wire logic       boot_select_in_oe
);
   logic [2:0]  up_q;
   logic [13:0] run_q;
   logic [15:0] osc_q;
   logic        cfg_q, done_q, live;
   // live well after both resets so mirrors match the core
   assign live = (up_q == 3'h7) && osc_clk_enable;
   always_ff @(posedge sys_clk) begin
      up_q   <= (!rst_n || !reset_in_n) ? 3'h0 : up_q + 3'(up_q != 3'h7);
      run_q  <= !serial_out_pin_oe ? 14'h0000 : run_q + 14'(run_q != 14'h3fff);
      osc_q  <= !rst_n ? 16'h0000 : osc_q + 16'(osc_q != 16'hffff);
      cfg_q  <= !live ? 1'b0 : (reg_wr && reg_addr == 8'h00) ? reg_wdata[7] : cfg_q;
      done_q <= !live ? 1'b0 : (reg_wr && reg_addr == 8'h04) ? reg_wdata[0] : done_q;
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // ==========================================
   // assertions
   chk_pull_only: assert property (serial_out_pin_o == 1'b0)
      else $error("serial output drives high");
   chk_quiet_reset: assert property (
      !reset_in_n [*4] |=> !serial_out_pin_oe && !timing_out_pin)
      else $error("outputs active in hard reset");
   chk_bit_min: assert property (live && $fell(serial_out_pin_oe) |-> run_q >= 14'h0363)
      else $error("low pulse shorter than a bit");
   chk_timing_sel: assert property (
      live && $past(live) |->
      timing_out_pin == ($past(cfg_q) ? $past(tx_space_symbol) : $past(preslot_sync)))
      else $error("timing pin source wrong");
   chk_boot_outs: assert property (
      live && !done_q |-> boot_led_status_oe && boot_status_aux_oe)
      else $error("boot status pins not driven");
   chk_select_in: assert property (live && !done_q |-> !boot_select_in_oe)
      else $error("boot select pin driven");
   chk_osc_early: assert property (osc_clk_enable |-> osc_q >= 16'(OSC_SETTLE - 1))
      else $error("clock released too early");
   chk_osc_late: assert property (osc_q == 16'(2 * OSC_SETTLE) |-> osc_clk_enable)
      else $error("clock never released");
endmodule
bind hsi_top hsi_top_asserts #(.OSC_SETTLE(OSC_SETTLE)) u_chk (
   .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .serial_out_pin_o, .serial_out_pin_oe,
   .reset_in_n, .preslot_sync, .tx_space_symbol, .timing_out_pin, .osc_clk_enable,
   .boot_led_status_oe, .boot_status_aux_oe, .boot_select_in_oe);

/* File: testbench.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin bad_count++; \
   $display("Error %s expected %h seen %h", n, e, a); end end
// ==========================================
// bench: register port, straps and host line
module testbench;
   import hsi_pkg::*;
   localparam int BIT = int'(DIV_115200);
   logic       sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reset_in_n = 1'b1;
   logic       rate_strap_low = 1'b0, rate_strap_high = 1'b0;
   logic       preslot_sync = 1'b0, tx_space_symbol = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdv;
   int         bad_count = 0, compares = 0;
   wire logic [7:0] reg_rdata;
   wire logic  serial_in_pin, serial_out_pin_o, serial_out_pin_oe, timing_out_pin, osc_clk_enable;
   wire logic  boot_led_status_o, boot_led_status_oe, boot_status_aux_o, boot_status_aux_oe;
   wire logic  boot_select_in_o, boot_select_in_oe;
   hsi_top #(.OSC_SETTLE(16)) u_dut (
      .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .serial_in_pin,
      .serial_out_pin_i(~serial_out_pin_oe), .serial_out_pin_o, .serial_out_pin_oe,
      .rate_strap_low, .rate_strap_high, .reset_in_n, .preslot_sync, .tx_space_symbol,
      .timing_out_pin, .osc_clk_enable, .boot_led_status_o, .boot_led_status_oe,
      .boot_led_status_i(boot_led_status_oe ? boot_led_status_o : 1'b1),
      .boot_status_aux_o, .boot_status_aux_oe,
      .boot_status_aux_i(boot_status_aux_oe ? boot_status_aux_o : 1'b1),
      .boot_select_in_o, .boot_select_in_oe,
      .boot_select_in_i(boot_select_in_oe ? boot_select_in_o : 1'b0));
   hsi_host_model #(.BIT(BIT)) u_host (
      .sys_clk, .line_rx(~serial_out_pin_oe), .line_tx(serial_in_pin));
   initial forever #5 sys_clk = ~sys_clk;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1 rdv = reg_rdata;
   endtask
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // tests take ~30k cycles
   initial begin
      repeat (60_000) @(posedge sys_clk);
      bad_count++;
      print_verdict();
   end
   initial begin
      for (int c = 3; c >= 0; c--) begin
         @(posedge sys_clk);
         {rate_strap_high, rate_strap_low} <= 2'(c);
         rst_n <= 1'b0;
         repeat (12) @(posedge sys_clk);
         rst_n <= 1'b1;
         repeat (40) @(posedge sys_clk);
         `CHK("osc_clk_enable", 1'b1, osc_clk_enable)
         rd(REG_STATUS);
         `CHK("rate_sel", 2'(c), rdv[1:0])
      end
      {rate_strap_high, rate_strap_low} <= 2'h3;
      wr(REG_CONFIG, 8'h5A);
      wr(8'h10, 8'h3C);
      rd(REG_STATUS);
      `CHK("held rate", 3'h4, rdv[2:0])
      $display("test straps done");
      {rate_strap_high, rate_strap_low} <= 2'h0;
      rd(8'h20);
      `CHK("unmapped", 8'h00, rdv)
      reset_in_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rd(REG_CONFIG);
      `CHK("config in reset", 8'h00, rdv)
      reset_in_n <= 1'b1;
      repeat (8) @(posedge sys_clk);
      rd(8'h10);
      `CHK("memory kept", 8'h3C, rdv)
      $display("test reset done");
      @(posedge sys_clk);
      preslot_sync <= 1'b1;
      repeat (3) @(negedge sys_clk);
      `CHK("timing preslot", 1'b1, timing_out_pin)
      wr(REG_CONFIG, 8'h80);
      repeat (2) @(negedge sys_clk);
      `CHK("timing mark", 1'b0, timing_out_pin)
      @(posedge sys_clk);
      tx_space_symbol <= 1'b1;
      repeat (2) @(negedge sys_clk);
      `CHK("timing space", 1'b1, timing_out_pin)
      wr(REG_BOOT_CTRL, 8'h02);
      @(negedge sys_clk);
      `CHK("boot pins", 5'h1C, {boot_led_status_oe, boot_led_status_o, boot_status_aux_oe,
         boot_status_aux_o, boot_select_in_oe})
      wr(REG_GPIO_OE, 8'h07);
      wr(REG_GPIO_OUT, 8'h05);
      wr(REG_BOOT_CTRL, 8'h01);
      @(negedge sys_clk);
      `CHK("gpio pins", 5'h1B, {boot_led_status_o, boot_status_aux_oe, boot_status_aux_o,
         boot_select_in_oe, boot_select_in_o})
      $display("test pins done");
      // both directions at once; the second write lands while busy
      fork
         u_host.send(8'hC6, 1'b1);
         begin
            wr(REG_TX_DATA, 8'h35);
            wr(REG_TX_DATA, 8'hFF);
            rd(REG_STATUS);
            `CHK("tx busy", 1'b1, rdv[4])
         end
      join
      repeat (BIT * 11) @(posedge sys_clk);
      `CHK("host count", 1, u_host.got_cnt)
      `CHK("host byte", 8'h35, u_host.got_byte)
      rd(REG_GPIO_IN);
      `CHK("gpio in", 8'h05, rdv)
      rd(REG_RX_DATA);
      `CHK("rx byte", 8'hC6, rdv)
      u_host.send(8'h5A, 1'b0);
      repeat (BIT) @(posedge sys_clk);
      rd(REG_STATUS);
      `CHK("frame flags", 2'h1, rdv[7:6])
      $display("test serial done");
      print_verdict();
   end
endmodule
